/* File: hw/sifs_deglitch.v */
// De-glitch filter: output follows input once stable for a set count
module sifs_deglitch #(
  parameter CYCLES = 200,
  parameter CW = 8
) (
  input wire core_clk,
  input wire sys_rst,
  input wire raw,
  output reg filt
);
  reg [CW-1:0] cnt;
  // ****************************************
  // Stability counter
  // ****************************************
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= {CW{1'b0}};
      filt <= 1'b0;
    end else if (raw == filt) begin
      cnt <= {CW{1'b0}};
    end else if (cnt == CYCLES[CW-1:0] - 1'b1) begin
      // Change accepted only after full stable window
      cnt <= {CW{1'b0}};
      filt <= raw; // RULE3
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule

/* File: hw/sifs_fault_status.v */
// Sensor input fault status register with clear-on-read flags
`include "sifs_regs.vh"
module sifs_fault_status #(
  parameter DEGLITCH_CYC = `SIFS_DEGLITCH_CYC,
  parameter CW = 8
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [3:0] integrity_low_fail,
  input wire [3:0] integrity_high_fail,
  input wire [3:0] overvolt_low_fail,
  input wire [3:0] overvolt_high_fail,
  input wire rd_en,
  input wire [7:0] rd_addr,
  output reg [15:0] rd_data,
  output reg rd_valid
);
  // Input vectors index sensor input one..four as bit 0..3.
  // Inputs one and three are the cosine pair, two and four the sine pair.
  localparam [15:0] FLAGS_RST = `SIFS_FAULT_FLAGS_RST;

  // ****************************************
  // Synchronisers
  // ****************************************
  // Comparator levels arrive unclocked, so each line gets two flops.
  reg [3:0] il_meta;
  reg [3:0] il_sync;
  reg [3:0] ih_meta;
  reg [3:0] ih_sync;
  reg [3:0] ol_meta;
  reg [3:0] ol_sync;
  reg [3:0] oh_meta;
  reg [3:0] oh_sync;
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      il_meta <= 4'h0;
      il_sync <= 4'h0;
      ih_meta <= 4'h0;
      ih_sync <= 4'h0;
      ol_meta <= 4'h0;
      ol_sync <= 4'h0;
      oh_meta <= 4'h0;
      oh_sync <= 4'h0;
    end else begin
      il_meta <= integrity_low_fail;
      il_sync <= il_meta;
      ih_meta <= integrity_high_fail;
      ih_sync <= ih_meta;
      ol_meta <= overvolt_low_fail;
      ol_sync <= ol_meta;
      oh_meta <= overvolt_high_fail;
      oh_sync <= oh_meta;
    end
  end

  // ****************************************
  // De-glitch on integrity results
  // ****************************************
  // Overvoltage lines skip the filter; only integrity checks wait.
  wire [7:0] integ_raw;
  wire [7:0] integ_filt;
  assign integ_raw = {il_sync, ih_sync};
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_dg
      sifs_deglitch #(
        .CYCLES(DEGLITCH_CYC),
        .CW(CW)
      ) u_dg (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .raw(integ_raw[g]), // RULE3
        .filt(integ_filt[g])
      );
    end
  endgenerate
  wire [3:0] il_filt;
  wire [3:0] ih_filt;
  assign il_filt = integ_filt[7:4];
  assign ih_filt = integ_filt[3:0];

  // ****************************************
  // Low integrity results per input
  // ****************************************
  // Filtered, so a dip shorter than the window never logs.
  wire in_one_low_integrity;
  wire in_two_low_integrity;
  wire in_three_low_integrity;
  wire in_four_low_integrity;
  assign in_one_low_integrity = il_filt[0];
  assign in_two_low_integrity = il_filt[1];
  assign in_three_low_integrity = il_filt[2];
  assign in_four_low_integrity = il_filt[3];

  // ****************************************
  // High integrity results per input
  // ****************************************
  // Same filter as the low side; both edges need the full window.
  wire in_one_high_integrity;
  wire in_two_high_integrity;
  wire in_three_high_integrity;
  wire in_four_high_integrity;
  assign in_one_high_integrity = ih_filt[0];
  assign in_two_high_integrity = ih_filt[1];
  assign in_three_high_integrity = ih_filt[2];
  assign in_four_high_integrity = ih_filt[3];

  // ****************************************
  // Low overvoltage results per input
  // ****************************************
  // Unfiltered: logged three edges after the comparator rises.
  wire in_one_low_overvolt;
  wire in_two_low_overvolt;
  wire in_three_low_overvolt;
  wire in_four_low_overvolt;
  assign in_one_low_overvolt = ol_sync[0];
  assign in_two_low_overvolt = ol_sync[1];
  assign in_three_low_overvolt = ol_sync[2];
  assign in_four_low_overvolt = ol_sync[3];

  // ****************************************
  // High overvoltage results per input
  // ****************************************
  // Unfiltered, like the low side.
  wire in_one_high_overvolt;
  wire in_two_high_overvolt;
  wire in_three_high_overvolt;
  wire in_four_high_overvolt;
  assign in_one_high_overvolt = oh_sync[0];
  assign in_two_high_overvolt = oh_sync[1];
  assign in_three_high_overvolt = oh_sync[2];
  assign in_four_high_overvolt = oh_sync[3];

  // ****************************************
  // Register layout
  // ****************************************
  // Each nibble runs four, two, three, one from its top bit.
  wire [15:0] detect;
  assign detect[`SIFS_LOW_INTEG_POS+3] = in_four_low_integrity; // RULE1 RULE8
  assign detect[`SIFS_LOW_INTEG_POS+2] = in_two_low_integrity; // RULE1
  assign detect[`SIFS_LOW_INTEG_POS+1] = in_three_low_integrity; // RULE1
  assign detect[`SIFS_LOW_INTEG_POS] = in_one_low_integrity; // RULE1
  assign detect[`SIFS_HIGH_INTEG_POS+3] = in_four_high_integrity; // RULE2
  assign detect[`SIFS_HIGH_INTEG_POS+2] = in_two_high_integrity; // RULE2
  assign detect[`SIFS_HIGH_INTEG_POS+1] = in_three_high_integrity; // RULE2
  assign detect[`SIFS_HIGH_INTEG_POS] = in_one_high_integrity; // RULE2
  assign detect[`SIFS_LOW_OV_POS+3] = in_four_low_overvolt; // RULE4
  assign detect[`SIFS_LOW_OV_POS+2] = in_two_low_overvolt; // RULE4
  assign detect[`SIFS_LOW_OV_POS+1] = in_three_low_overvolt; // RULE4
  assign detect[`SIFS_LOW_OV_POS] = in_one_low_overvolt; // RULE4
  assign detect[`SIFS_HIGH_OV_POS+3] = in_four_high_overvolt; // RULE5
  assign detect[`SIFS_HIGH_OV_POS+2] = in_two_high_overvolt; // RULE5
  assign detect[`SIFS_HIGH_OV_POS+1] = in_three_high_overvolt; // RULE5
  assign detect[`SIFS_HIGH_OV_POS] = in_one_high_overvolt; // RULE5

  // ****************************************
  // Read decode
  // ****************************************
  reg addr_match;
  wire hit;
  always @* begin
    addr_match = 1'b0;
    case (rd_addr)
      `SIFS_FAULT_FLAGS_OFS: begin
        addr_match = 1'b1;
      end
      default: begin
        addr_match = 1'b0;
      end
    endcase
  end
  assign hit = rd_en && addr_match;

  // ****************************************
  // Flags
  // ****************************************
  // A read reloads each flag from live detect instead of zero, so an
  // event in the clearing cycle survives: set beats clear.
  wire [15:0] flags;
  genvar b;
  generate
    for (b = 0; b < 16; b = b + 1) begin : g_flag
      reg flag_q;
      wire keep;
      wire next_flag;
      assign keep = hit ? 1'b0 : flag_q; // RULE6
      assign next_flag = keep | detect[b]; // RULE9
      always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          flag_q <= FLAGS_RST[b]; // RULE7
        end else begin
          flag_q <= next_flag;
        end
      end
      assign flags[b] = flag_q;
    end
  endgenerate

  // ****************************************
  // Read port
  // ****************************************
  // Unmapped addresses read as zero and leave the flags alone.
  reg [15:0] next_rd_data;
  wire next_rd_valid;
  always @* begin
    next_rd_data = 16'h0000;
    if (hit) begin
      next_rd_data = flags; // RULE6
    end else begin
      next_rd_data = 16'h0000;
    end
  end
  assign next_rd_valid = rd_en;
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= FLAGS_RST;
      rd_valid <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end
endmodule

/* File: hw/sifs_regs.vh */
// Register offsets, field positions, reset values and timing for the fault flags
// Functional notes
// RULE1: Low integrity indicators at bits 15..12
// RULE2: High integrity indicators at bits 11..8
// RULE3: Integrity results need 5 us stable
// RULE4: Low overvoltage flags at bits 7..4
// RULE5: High overvoltage flags at bits 3..0
// RULE6: Reading returns flags, then clears them
// RULE7: Register at offset 0xF, resets zero
// RULE8: Inputs 1,3 cosine pair; 2,4 sine
// RULE9: New event during clearing read wins
`ifndef SIFS_REGS_VH
`define SIFS_REGS_VH
// ****************************************
// Map
// ****************************************
`define SIFS_FAULT_FLAGS_OFS 8'h0F
`define SIFS_FAULT_FLAGS_RST 16'h0000
// ****************************************
// Field base positions (nibble order four, two, three, one)
// ****************************************
`define SIFS_LOW_INTEG_POS 12
`define SIFS_HIGH_INTEG_POS 8
`define SIFS_LOW_OV_POS 4
`define SIFS_HIGH_OV_POS 0
// ****************************************
// Timing
// ****************************************
`define SIFS_DEGLITCH_NS 5000
`define SIFS_CLK_PERIOD_NS 25
`define SIFS_DEGLITCH_CYC ((`SIFS_DEGLITCH_NS + `SIFS_CLK_PERIOD_NS - 1) / `SIFS_CLK_PERIOD_NS)
`endif

/* File: verification/sifs_cmp.sv */
// Comparator model: fault levels settle a few ns after each request
module sifs_cmp (input wire [15:0] req, output wire [3:0] integrity_low_fail,
  integrity_high_fail, overvolt_low_fail, overvolt_high_fail);
  timeunit 1ns / 1ps;
  assign #7 {integrity_low_fail, integrity_high_fail, overvolt_low_fail,
    overvolt_high_fail} = req;
endmodule

/* File: verification/sifs_fault_status_tb.sv */
// Bench for the fault status register
module sifs_fault_status_tb;
  timeunit 1ns / 1ps;
  logic core_clk = 0, sys_rst = 1, rd_en = 0, rd_valid;
  logic [7:0] rd_addr = 8'h00;
  logic [15:0] req = 16'h0000, rd_data, e;
  wire [3:0] integrity_low_fail, integrity_high_fail, overvolt_low_fail,
    overvolt_high_fail;
  int miscompares = 0, tests_run = 0;
  always #12.5 core_clk = ~core_clk;
  sifs_cmp u_sifs_cmp (.*);
  sifs_fault_status #(.DEGLITCH_CYC(4)) u_sifs_fault_status (.*);
  function [3:0] m(input [3:0] v);
    m = {v[3], v[1], v[2], v[0]};
  endfunction
  task rd(input [7:0] a, input [15:0] e1, e2);
    @(posedge core_clk) {rd_en, rd_addr} <= {1'b1, a};
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk) rd_en <= i == 0;
      @(negedge core_clk) tests_run++;
      if ({rd_valid, rd_data} !== {1'b1, i ? e2 : e1}) begin
        miscompares++;
        $display("CHECK FAILED read exp %h got %h", {1'b1, i ? e2 : e1},
          {rd_valid, rd_data});
      end
    end
  endtask
  task s_reset;
    rd(8'h0F, 16'h0000, 16'h0000);
    rd(8'hA5, 16'h0000, 16'h0000);
  endtask
  task s_faults;
    for (int k = 0; k < 4; k++) begin
      e = {2{m(4'h1 << k), m(4'h8 >> k)}};
      @(posedge core_clk) req <= {2{4'h1 << k, 4'h8 >> k}};
      repeat (16) @(posedge core_clk);
      rd(8'h0F, e, e);
      @(posedge core_clk) req <= 16'h0000;
      repeat (16) @(posedge core_clk);
      rd(8'h0F, e, 16'h0000);
    end
  endtask
  task s_glitch;
    @(posedge core_clk) req <= 16'hFF00;
    repeat (3) @(posedge core_clk);
    req <= 16'h0000;
    repeat (16) @(posedge core_clk);
    rd(8'h0F, 16'h0000, 16'h0000);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    s_reset;
    s_faults;
    s_glitch;
    complete_run;
  end
  initial begin
    repeat (4000) @(posedge core_clk);
    miscompares++;
    complete_run;
  end
endmodule

/* File: verification/sifs_props.sv */
// Port checks for the fault status register
module sifs_chk #(parameter DEGLITCH_CYC = 4) (input wire core_clk, sys_rst,
  rd_en, rd_valid, input wire [7:0] rd_addr, input wire [15:0] rd_data,
  input wire [3:0] integrity_low_fail, integrity_high_fail,
  overvolt_low_fail, overvolt_high_fail);
  timeunit 1ns / 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire rf = rd_en && rd_addr == 8'h0F;
  property p_a; rd_en |=> rd_valid; endproperty
  a_a: assert property (p_a) else $error("valid");
  property p_b; !rd_en |=> !rd_valid; endproperty
  a_b: assert property (p_b) else $error("stray");
  property p_c; rd_en && !rf |=> rd_data == 16'h0000; endproperty
  a_c: assert property (p_c) else $error("unmapped");
  property p_d; $fell(sys_rst) |-> rd_data == 16'h0000; endproperty
  a_d: assert property (p_d) else $error("reset");
  property p_e; overvolt_high_fail[2] [*4] ##0 rf |=> rd_data[1]; endproperty
  a_e: assert property (p_e) else $error("high ov");
  property p_f; overvolt_low_fail[1] [*4] ##0 rf |=> rd_data[6]; endproperty
  a_f: assert property (p_f) else $error("low ov");
  // Twelve samples cover sync plus filter window with margin
  property p_g; integrity_low_fail[3] [*8] ##1 integrity_low_fail[3] [*4]
    ##0 rf |=> rd_data[15]; endproperty
  a_g: assert property (p_g) else $error("low integ");
  property p_h; integrity_high_fail[2] [*8] ##1 integrity_high_fail[2] [*4]
    ##0 rf |=> rd_data[9]; endproperty
  a_h: assert property (p_h) else $error("high integ");
  c_a: cover property (rf ##1 rf);
  c_b: cover property (rd_en && !rf);
  c_c: cover property (rf && integrity_low_fail != 4'h0);
endmodule
bind sifs_fault_status sifs_chk #(.DEGLITCH_CYC(DEGLITCH_CYC)) u_sifs_chk (.*);
